// ===== include/lxu_pkg.sv
// Shared constants and types of the logic-test and exclusive-OR unit.
package lxu_pkg;

   // ------------------------------------------------------------------
   // Datapath widths and register ranges
   // ------------------------------------------------------------------
   localparam int                DATA_W        = 32;
   localparam int                IMM_W         = 16;
   localparam int                REG_IDX_W     = 5;
   localparam logic [4:0]        LAST_REG      = 5'h1B;  // Register 27.
   localparam logic [4:0]        LAST_EXT_REG  = 5'h07;  // Register 7.
   localparam logic [DATA_W-1:0] ZERO_WORD     = 32'h00000000;
   localparam int                SIGN_BIT      = DATA_W - 1;

   // ------------------------------------------------------------------
   // Operand mode field codes
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_CODE_0 = 2'h0;
   localparam logic [1:0] MODE_CODE_1 = 2'h1;
   localparam logic [1:0] MODE_CODE_2 = 2'h2;
   localparam logic [1:0] MODE_CODE_3 = 2'h3;

   // ------------------------------------------------------------------
   // Instructions, operand kinds and mode-field formats
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_BIT_TEST_THREE_OPERAND,
      OP_XOR_TWO_OPERAND,
      OP_XOR_THREE_OPERAND,
      OP_IDLE
   } lxu_op_e;

   typedef enum logic [1:0] {
      KIND_REGISTER,
      KIND_DIRECT,
      KIND_INDIRECT,
      KIND_IMMEDIATE
   } lxu_kind_e;

   typedef enum logic [1:0] {
      FMT_THREE_FIRST,
      FMT_THREE_SECOND,
      FMT_GENERAL
   } lxu_fmt_e;

   // ------------------------------------------------------------------
   // Condition flag positions
   // ------------------------------------------------------------------
   localparam int         FLAGS_W                = 7;
   localparam int         FLAG_CARRY             = 0;
   localparam int         FLAG_OVERFLOW          = 1;
   localparam int         FLAG_UNDERFLOW         = 2;
   localparam int         FLAG_NEGATIVE          = 3;
   localparam int         FLAG_ZERO              = 4;
   localparam int         FLAG_LATCHED_OVERFLOW  = 5;
   localparam int         FLAG_LATCHED_UNDERFLOW = 6;
   localparam logic [6:0] FLAGS_RESET            = 7'h00;

   // ------------------------------------------------------------------
   // APB register map
   // ------------------------------------------------------------------
   localparam int          APB_ADDR_W   = 12;
   localparam logic [11:0] ADDR_FLAGS   = 12'h000;
   localparam logic [11:0] ADDR_RESULT  = 12'h004;
   localparam logic [11:0] ADDR_CTRL    = 12'h008;
   localparam int          CTRL_ENABLE  = 0;
   localparam logic        ENABLE_RESET = 1'b1;

endpackage

// ===== core/lxu_operand_sel.sv
// Operand mode-field decoder and operand selector for one source.
`timescale 1ns/100ps

module lxu_operand_sel #(
   parameter lxu_pkg::lxu_fmt_e FORMAT = lxu_pkg::FMT_GENERAL
) (
   // Mode field.
   input  wire logic [1:0]                     i_mode,
   // Candidate operand values from operand fetch.
   input  wire logic [lxu_pkg::DATA_W-1:0]     i_reg_data,
   input  wire logic [lxu_pkg::DATA_W-1:0]     i_mem_data,
   input  wire logic [lxu_pkg::IMM_W-1:0]      i_imm,
   // Selected operand and its addressing kind.
   output      logic [lxu_pkg::DATA_W-1:0]     o_operand,
   output      lxu_pkg::lxu_kind_e             o_kind
);

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------

   // The first source alternates register and indirect, the second
   // source splits at the upper bit, the general form has four kinds.
   always_comb begin
      o_kind = lxu_pkg::KIND_REGISTER;
      case (FORMAT)
         lxu_pkg::FMT_THREE_FIRST: begin
            if (i_mode == lxu_pkg::MODE_CODE_1 || i_mode == lxu_pkg::MODE_CODE_3) begin
               o_kind = lxu_pkg::KIND_INDIRECT;
            end
         end
         lxu_pkg::FMT_THREE_SECOND: begin
            if (i_mode == lxu_pkg::MODE_CODE_2 || i_mode == lxu_pkg::MODE_CODE_3) begin
               o_kind = lxu_pkg::KIND_INDIRECT;
            end
         end
         default: begin
            case (i_mode)
               lxu_pkg::MODE_CODE_1: o_kind = lxu_pkg::KIND_DIRECT;
               lxu_pkg::MODE_CODE_2: o_kind = lxu_pkg::KIND_INDIRECT;
               lxu_pkg::MODE_CODE_3: o_kind = lxu_pkg::KIND_IMMEDIATE;
               default:              o_kind = lxu_pkg::KIND_REGISTER;
            endcase
         end
      endcase
   end

   // Memory kinds take the fetched word; the immediate is zero-extended
   // because every operand of these instructions is unsigned.
   always_comb begin
      case (o_kind)
         lxu_pkg::KIND_REGISTER:  o_operand = i_reg_data;
         lxu_pkg::KIND_IMMEDIATE: o_operand = {{(lxu_pkg::DATA_W-lxu_pkg::IMM_W){1'b0}}, i_imm};
         default:                 o_operand = i_mem_data;
      endcase
   end

endmodule

// ===== core/lxu_logic_unit.sv
// Logic-test and exclusive-OR execute unit with its APB register slave.
`timescale 1ns/100ps

// Contract
// - Bit test ANDs operands, stores nothing; the code still loads the result word.
// - Bit test updates flags for any destination.
// - Two-operand XOR writes source XOR destination.
// - Three-operand XOR writes sources into destination.
// - XOR flags change only for destinations 0-7.
// - N=MSB, Z=zero, V,UF cleared, rest kept.
// - First-source field: register, indirect alternately.
// - Second-source field: two register, two indirect.
// - General field: register, direct, indirect, immediate.
// - Bit test uses three-operand mode fields.
module lxu_logic_unit (
   // Clock and reset.
   input  wire logic                              i_core_clk,
   input  wire logic                              i_rst,
   // Instruction issue from decode and operand fetch.
   input  wire logic                              i_issue_valid,
   output      logic                              o_issue_ready,
   input  wire lxu_pkg::lxu_op_e                  i_opcode,
   input  wire logic [1:0]                        i_src1_mode,
   input  wire logic [1:0]                        i_src2_mode,
   input  wire logic [lxu_pkg::REG_IDX_W-1:0]     i_dst_index,
   input  wire logic [lxu_pkg::DATA_W-1:0]        i_src1_reg_data,
   input  wire logic [lxu_pkg::DATA_W-1:0]        i_src1_mem_data,
   input  wire logic [lxu_pkg::DATA_W-1:0]        i_src2_reg_data,
   input  wire logic [lxu_pkg::DATA_W-1:0]        i_src2_mem_data,
   input  wire logic [lxu_pkg::IMM_W-1:0]         i_immediate,
   // Result write-back and completion.
   output      logic                              o_wr_valid,
   output      logic [lxu_pkg::REG_IDX_W-1:0]     o_wr_index,
   output      logic [lxu_pkg::DATA_W-1:0]        o_wr_data,
   output      logic                              o_done,
   output      lxu_pkg::lxu_kind_e                o_src1_kind,
   output      lxu_pkg::lxu_kind_e                o_src2_kind,
   output      logic [lxu_pkg::FLAGS_W-1:0]       o_flags,
   // APB slave.
   input  wire logic                              i_psel,
   input  wire logic                              i_penable,
   input  wire logic                              i_pwrite,
   input  wire logic [lxu_pkg::APB_ADDR_W-1:0]    i_paddr,
   input  wire logic [lxu_pkg::DATA_W-1:0]        i_pwdata,
   output      logic [lxu_pkg::DATA_W-1:0]        o_prdata,
   output      logic                              o_pready,
   output      logic                              o_pslverr
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [lxu_pkg::FLAGS_W-1:0]   flags_reg;
   logic [lxu_pkg::FLAGS_W-1:0]   flags_next;
   logic [lxu_pkg::DATA_W-1:0]    result_reg;
   logic                          enable_reg;
   logic                          wr_valid_reg;
   logic [lxu_pkg::REG_IDX_W-1:0] wr_index_reg;
   logic [lxu_pkg::DATA_W-1:0]    wr_data_reg;
   logic                          done_reg;
   lxu_pkg::lxu_kind_e            src1_kind_reg;
   lxu_pkg::lxu_kind_e            src2_kind_reg;
   logic [lxu_pkg::DATA_W-1:0]    prdata_reg;
   logic                          pready_reg;
   logic                          pslverr_reg;

   logic [lxu_pkg::DATA_W-1:0]    first_operand;
   logic [lxu_pkg::DATA_W-1:0]    second_operand;
   lxu_pkg::lxu_kind_e            first_kind;
   lxu_pkg::lxu_kind_e            second_kind;
   logic [lxu_pkg::DATA_W-1:0]    general_operand;
   lxu_pkg::lxu_kind_e            general_kind;
   logic [lxu_pkg::DATA_W-1:0]    operand_a;
   logic [lxu_pkg::DATA_W-1:0]    operand_b;
   logic [lxu_pkg::DATA_W-1:0]    logic_out;
   logic                          accept;
   logic                          is_test;
   logic                          is_xor;
   logic                          flag_update;
   logic                          apb_setup;
   logic                          apb_commit;
   logic                          addr_mapped;
   logic [lxu_pkg::DATA_W-1:0]    read_mux;

   // ------------------------------------------------------------------
   // Operand decode
   // ------------------------------------------------------------------

   // Three selectors run side by side; the opcode picks which pair counts.
   lxu_operand_sel #(.FORMAT(lxu_pkg::FMT_THREE_FIRST)) u_sel_first (
      .i_mode     (i_src1_mode),
      .i_reg_data (i_src1_reg_data),
      .i_mem_data (i_src1_mem_data),
      .i_imm      (i_immediate),
      .o_operand  (first_operand),
      .o_kind     (first_kind)
   );

   lxu_operand_sel #(.FORMAT(lxu_pkg::FMT_THREE_SECOND)) u_sel_second (
      .i_mode     (i_src2_mode),
      .i_reg_data (i_src2_reg_data),
      .i_mem_data (i_src2_mem_data),
      .i_imm      (i_immediate),
      .o_operand  (second_operand),
      .o_kind     (second_kind)
   );

   lxu_operand_sel #(.FORMAT(lxu_pkg::FMT_GENERAL)) u_sel_general (
      .i_mode     (i_src1_mode),
      .i_reg_data (i_src1_reg_data),
      .i_mem_data (i_src1_mem_data),
      .i_imm      (i_immediate),
      .o_operand  (general_operand),
      .o_kind     (general_kind)
   );

   // ------------------------------------------------------------------
   // Execute
   // ------------------------------------------------------------------

   // The two-operand form pairs its source with the destination register.
   assign accept  = i_issue_valid && enable_reg;
   assign is_test = i_opcode == lxu_pkg::OP_BIT_TEST_THREE_OPERAND;
   assign is_xor  = i_opcode == lxu_pkg::OP_XOR_TWO_OPERAND ||
                    i_opcode == lxu_pkg::OP_XOR_THREE_OPERAND;

   always_comb begin
      case (i_opcode)
         lxu_pkg::OP_XOR_TWO_OPERAND: begin
            operand_a = general_operand;
            operand_b = i_src2_reg_data;
         end
         default: begin
            operand_a = first_operand;
            operand_b = second_operand;
         end
      endcase
   end

   // The test result only sets the flags and the result word, never written back.
   assign logic_out   = is_test ? (operand_a & operand_b) : (operand_a ^ operand_b);
   assign flag_update = accept &&
                        (is_test ||
                         (is_xor && i_dst_index <= lxu_pkg::LAST_EXT_REG));

   // Write-back fires one cycle after issue for the XOR forms only.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_valid_reg <= 1'b0;
         wr_index_reg <= '0;
         wr_data_reg  <= lxu_pkg::ZERO_WORD;
         done_reg     <= 1'b0;
      end else begin
         wr_valid_reg <= accept && is_xor;
         done_reg     <= accept && (is_test || is_xor);
         if (accept && is_xor) begin
            wr_index_reg <= i_dst_index;
            wr_data_reg  <= logic_out;
         end
      end
   end

   // Addressing kinds are held for the memory stage to see.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         src1_kind_reg <= lxu_pkg::KIND_REGISTER;
         src2_kind_reg <= lxu_pkg::KIND_REGISTER;
         result_reg    <= lxu_pkg::ZERO_WORD;
      end else if (accept && (is_test || is_xor)) begin
         result_reg <= logic_out;
         if (i_opcode == lxu_pkg::OP_XOR_TWO_OPERAND) begin
            src1_kind_reg <= general_kind;
            src2_kind_reg <= lxu_pkg::KIND_REGISTER;
         end else begin
            src1_kind_reg <= first_kind;
            src2_kind_reg <= second_kind;
         end
      end
   end

   // ------------------------------------------------------------------
   // Condition flags
   // ------------------------------------------------------------------

   // An instruction update wins over a software write in the same cycle,
   // so a flag the program relies on is never lost to a late APB store.
   always_comb begin
      flags_next = flags_reg;
      if (flag_update) begin
         flags_next[lxu_pkg::FLAG_NEGATIVE]  = logic_out[lxu_pkg::SIGN_BIT];
         flags_next[lxu_pkg::FLAG_ZERO]      = logic_out == lxu_pkg::ZERO_WORD;
         flags_next[lxu_pkg::FLAG_OVERFLOW]  = 1'b0;
         flags_next[lxu_pkg::FLAG_UNDERFLOW] = 1'b0;
      end else if (apb_commit && i_pwrite && i_paddr == lxu_pkg::ADDR_FLAGS) begin
         flags_next = i_pwdata[lxu_pkg::FLAGS_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         flags_reg <= lxu_pkg::FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------

   // Every transfer takes exactly one wait-free access cycle.
   assign apb_setup   = i_psel && !i_penable;
   assign apb_commit  = i_psel && i_penable && pready_reg;
   assign addr_mapped = i_paddr == lxu_pkg::ADDR_FLAGS ||
                        i_paddr == lxu_pkg::ADDR_RESULT ||
                        i_paddr == lxu_pkg::ADDR_CTRL;

   always_comb begin
      read_mux = lxu_pkg::ZERO_WORD;
      case (i_paddr)
         lxu_pkg::ADDR_FLAGS:  read_mux[lxu_pkg::FLAGS_W-1:0] = flags_reg;
         lxu_pkg::ADDR_RESULT: read_mux = result_reg;
         lxu_pkg::ADDR_CTRL:   read_mux[lxu_pkg::CTRL_ENABLE] = enable_reg;
         default:              read_mux = lxu_pkg::ZERO_WORD;
      endcase
   end

   // Read data is captured in the setup cycle and held through access.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= lxu_pkg::ZERO_WORD;
      end else begin
         pready_reg  <= apb_setup;
         pslverr_reg <= apb_setup && !addr_mapped;
         if (apb_setup) begin
            prdata_reg <= i_pwrite ? lxu_pkg::ZERO_WORD : read_mux;
         end
      end
   end

   // Clearing the enable bit stalls issue; the result word is read-only.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         enable_reg <= lxu_pkg::ENABLE_RESET;
      end else if (apb_commit && i_pwrite && i_paddr == lxu_pkg::ADDR_CTRL) begin
         enable_reg <= i_pwdata[lxu_pkg::CTRL_ENABLE];
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_issue_ready = enable_reg;
   assign o_wr_valid    = wr_valid_reg;
   assign o_wr_index    = wr_index_reg;
   assign o_wr_data     = wr_data_reg;
   assign o_done        = done_reg;
   assign o_src1_kind   = src1_kind_reg;
   assign o_src2_kind   = src2_kind_reg;
   assign o_flags       = flags_reg;
   assign o_prdata      = prdata_reg;
   assign o_pready      = pready_reg;
   assign o_pslverr     = pslverr_reg;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_take(lxu_pkg::lxu_op_e op);
      i_issue_valid && o_issue_ready && i_opcode == op;
   endsequence

   sequence s_done_write(logic w);
      o_done && o_wr_valid == w;
   endsequence

   property p_test_no_store;
      @(posedge i_core_clk) disable iff (i_rst)
      s_take(lxu_pkg::OP_BIT_TEST_THREE_OPERAND) |=> s_done_write(1'b0);
   endproperty
   a_test_no_store: assert property (p_test_no_store)
      else $error("bit test wrote a register");

   property p_test_flags_any_dst;
      @(posedge i_core_clk) disable iff (i_rst)
      s_take(lxu_pkg::OP_BIT_TEST_THREE_OPERAND) |=>
         o_flags[lxu_pkg::FLAG_ZERO] == (($past(first_operand) & $past(second_operand)) == 0);
   endproperty
   a_test_flags_any_dst: assert property (p_test_flags_any_dst)
      else $error("bit test zero flag wrong");

   property p_xor2_write;
      @(posedge i_core_clk) disable iff (i_rst)
      s_take(lxu_pkg::OP_XOR_TWO_OPERAND) |=> s_done_write(1'b1) ##0
         (o_wr_data == ($past(general_operand) ^ $past(i_src2_reg_data)));
   endproperty
   a_xor2_write: assert property (p_xor2_write)
      else $error("two-operand xor result wrong");

   property p_xor_three_operand_write;
      @(posedge i_core_clk) disable iff (i_rst)
      s_take(lxu_pkg::OP_XOR_THREE_OPERAND) |=> s_done_write(1'b1) ##0
         (o_wr_index == $past(i_dst_index) &&
          o_wr_data == ($past(first_operand) ^ $past(second_operand)));
   endproperty
   a_xor_three_operand_write: assert property (p_xor_three_operand_write)
      else $error("three-operand xor result wrong");

   property p_xor_high_dst_keeps;
      @(posedge i_core_clk) disable iff (i_rst)
      (accept && is_xor && i_dst_index > lxu_pkg::LAST_EXT_REG && !apb_commit) |=>
         $stable(o_flags);
   endproperty
   a_xor_high_dst_keeps: assert property (p_xor_high_dst_keeps)
      else $error("flags changed for high destination");

   property p_flag_values;
      @(posedge i_core_clk) disable iff (i_rst)
      flag_update |=> !o_flags[lxu_pkg::FLAG_OVERFLOW] && !o_flags[lxu_pkg::FLAG_UNDERFLOW] &&
         o_flags[lxu_pkg::FLAG_NEGATIVE] == $past(logic_out[lxu_pkg::SIGN_BIT]) &&
         o_flags[lxu_pkg::FLAG_CARRY] == $past(o_flags[lxu_pkg::FLAG_CARRY]) &&
         o_flags[lxu_pkg::FLAG_LATCHED_OVERFLOW] == $past(o_flags[lxu_pkg::FLAG_LATCHED_OVERFLOW]);
   endproperty
   a_flag_values: assert property (p_flag_values)
      else $error("flag update values wrong");

   property p_first_mode;
      @(posedge i_core_clk) disable iff (i_rst)
      (s_take(lxu_pkg::OP_XOR_THREE_OPERAND) ##0 i_src1_mode == lxu_pkg::MODE_CODE_2) |=>
         o_src1_kind == lxu_pkg::KIND_REGISTER;
   endproperty
   a_first_mode: assert property (p_first_mode)
      else $error("first source mode decode wrong");

   property p_second_mode;
      @(posedge i_core_clk) disable iff (i_rst)
      (s_take(lxu_pkg::OP_BIT_TEST_THREE_OPERAND) ##0 i_src2_mode == lxu_pkg::MODE_CODE_1) |=>
         o_src2_kind == lxu_pkg::KIND_REGISTER;
   endproperty
   a_second_mode: assert property (p_second_mode)
      else $error("second source mode decode wrong");

   property p_general_mode;
      @(posedge i_core_clk) disable iff (i_rst)
      (s_take(lxu_pkg::OP_XOR_TWO_OPERAND) ##0 i_src1_mode == lxu_pkg::MODE_CODE_1) |=>
         o_src1_kind == lxu_pkg::KIND_DIRECT;
   endproperty
   a_general_mode: assert property (p_general_mode)
      else $error("general source mode decode wrong");

   property p_one_cycle;
      @(posedge i_core_clk) disable iff (i_rst)
      !(accept && (is_test || is_xor)) |=> !o_done;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("completion without issue");

endmodule

// ===== bench/lxu_testbench.sv
// Self-checking testbench of the logic-test and exclusive-OR unit.
`timescale 1ns/100ps

module testbench;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_issue_valid = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   lxu_pkg::lxu_op_e i_opcode = lxu_pkg::OP_IDLE;
   logic [1:0] i_src1_mode = 2'h0, i_src2_mode = 2'h0;
   logic [4:0] i_dst_index = 5'h00, o_wr_index;
   logic [31:0] i_src1_reg_data = 32'h0, i_src1_mem_data = 32'h0, i_pwdata = 32'h0;
   logic [31:0] i_src2_reg_data = 32'h0, i_src2_mem_data = 32'h0, o_wr_data, o_prdata, rd;
   logic [15:0] i_immediate = 16'hA5A5;
   logic [11:0] i_paddr = 12'h000;
   logic [6:0] o_flags, fm;
   logic o_issue_ready, o_wr_valid, o_done, o_pready, o_pslverr, er;
   lxu_pkg::lxu_kind_e o_src1_kind, o_src2_kind;
   int err_total = 0, checked = 0, done_cnt = 0, n0;

   lxu_logic_unit u_lxu_logic_unit (.*);

   // Half-period toggle gives the 40 ns core clock.
   always #20 i_core_clk = ~i_core_clk;

   // Completion pulses are counted so back-to-back issues can be tallied.
   always @(posedge i_core_clk) if (o_done === 1'b1) done_cnt <= done_cnt + 1;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; only the watchdog may end the wait on a dead slave.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_core_clk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0; i_penable <= 1'b0;
      @(posedge i_core_clk);
   endtask

   task automatic issue(input lxu_pkg::lxu_op_e op, input logic [1:0] m1, m2,
                        input logic [4:0] dst, input logic [31:0] a, b, c, e);
      i_issue_valid <= 1'b1; i_opcode <= op; i_src1_mode <= m1; i_src2_mode <= m2;
      i_dst_index <= dst; i_src1_reg_data <= a; i_src1_mem_data <= b;
      i_src2_reg_data <= c; i_src2_mem_data <= e;
      @(posedge i_core_clk);
   endtask

   // Checks the one-cycle answer; the flag model updates only when told.
   task automatic fin(input logic wr, input logic [31:0] res, input logic [4:0] dst,
                      input logic upd);
      i_issue_valid <= 1'b0;
      #1;
      if (upd) fm = {fm[6:5], res == 32'h0, res[31], 2'b00, fm[0]};
      chk(o_done, 1'b1);
      chk(o_wr_valid, wr);
      if (wr) chk({o_wr_index, o_wr_data[26:0]}, {dst, res[26:0]});
      if (wr) chk(o_wr_data, res);
      chk(o_flags, fm);
      @(posedge i_core_clk);
      #1;
      chk({o_done, o_wr_valid}, 2'b00);
      @(posedge i_core_clk);
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // The tests take about a hundred cycles; 5000 means something is stuck.
   initial begin
      #200000;
      err_total++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      lxu_pkg::lxu_kind_e gk[4];
      logic [31:0] x;
      gk = '{lxu_pkg::KIND_REGISTER, lxu_pkg::KIND_DIRECT, lxu_pkg::KIND_INDIRECT,
             lxu_pkg::KIND_IMMEDIATE};
      fm = 7'h00;
      repeat (20) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      apb(0, lxu_pkg::ADDR_FLAGS, 0); chk(rd, 0);
      apb(0, lxu_pkg::ADDR_CTRL, 0); chk(rd, 1);
      issue(lxu_pkg::OP_XOR_THREE_OPERAND, 0, 0, 4, 32'h8000F0F0, 0, 32'h0000FFFF, 0);
      fin(1, 32'h80000F0F, 4, 1);
      apb(1, lxu_pkg::ADDR_FLAGS, 32'h7F); fm = 7'h7F;
      issue(lxu_pkg::OP_XOR_THREE_OPERAND, 0, 0, 9, 32'h1, 0, 32'h1, 0);
      fin(1, 32'h0, 9, 0);
      issue(lxu_pkg::OP_XOR_TWO_OPERAND, 0, 0, 7, 32'h1234, 0, 32'h1234, 0);
      fin(1, 32'h0, 7, 1);
      issue(lxu_pkg::OP_BIT_TEST_THREE_OPERAND, 0, 0, 27, 32'hF0000001, 0, 32'h80000003, 0);
      fin(0, 32'h80000001, 27, 1);
      apb(1, lxu_pkg::ADDR_RESULT, 0); chk(er, 0);
      apb(0, lxu_pkg::ADDR_RESULT, 0); chk(rd, 32'h80000001);
      apb(0, 12'h00C, 0); chk({rd[30:0], er}, 1);
      for (int m = 0; m < 4; m++) begin
         x = (m[0] ? 32'hF00 : 32'hF0) | (m[1] ? 32'hF00000 : 32'hF0000);
         issue(lxu_pkg::OP_XOR_THREE_OPERAND, m, m, 1, 32'hF0, 32'hF00, 32'hF0000, 32'hF00000);
         fin(1, x, 1, 1);
         chk({o_src1_kind, o_src2_kind}, {gk[m[0]*2], gk[m[1]*2]});
         issue(lxu_pkg::OP_BIT_TEST_THREE_OPERAND, m, m, 20, 32'hF0, 32'hF00, 32'hF0000, 0);
         fin(0, 0, 20, 1);
         chk({o_src1_kind, o_src2_kind}, {gk[m[0]*2], gk[m[1]*2]});
         x = (m == 0) ? 32'hF0 : (m == 3) ? 32'hA5A5 : 32'hF00;
         issue(lxu_pkg::OP_XOR_TWO_OPERAND, m, 0, 3, 32'hF0, 32'hF00, 0, 0);
         fin(1, x, 3, 1);
         chk({o_src1_kind, o_src2_kind}, {gk[m], lxu_pkg::KIND_REGISTER});
      end
      n0 = done_cnt;
      issue(lxu_pkg::OP_XOR_THREE_OPERAND, 0, 0, 5, 32'h5, 0, 0, 0);
      issue(lxu_pkg::OP_XOR_THREE_OPERAND, 0, 0, 6, 32'h0, 0, 32'h6, 0);
      fin(1, 32'h6, 6, 1);
      chk(done_cnt - n0, 2);
      issue(lxu_pkg::OP_IDLE, 0, 0, 2, 32'h1, 0, 0, 0);
      apb(1, lxu_pkg::ADDR_CTRL, 0); chk(o_issue_ready, 0);
      issue(lxu_pkg::OP_XOR_THREE_OPERAND, 0, 0, 2, 32'h1, 0, 0, 0);
      i_issue_valid <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      chk(done_cnt - n0, 2);
      chk(o_flags, fm);
      apb(1, lxu_pkg::ADDR_CTRL, 1); chk(o_issue_ready, 1);
      give_verdict();
   end
endmodule
